// File: logic/tunnel_codec_pkg.sv
// Functional notes
// - payload may carry radio data field
// - type A last byte unused bits zero
// - type A: whole bytes plus 1-8 bits
// - command bit 4: 0 type A, 1 bytes
// - front end sends 0000 none, 1000 type A
// - front end sends 1001 passive init forward
// - front end never sends reserved codes
// - decode admin with sender's code table
// - data field allowed with any admin code
// - type A bit count from byte length
package tunnel_codec_pkg;
	localparam logic [2:0] FRAME_MARKER = 3'h2;
	localparam int MARKER_MSB = 7;
	localparam int MARKER_LSB = 5;
	localparam int STRUCT_BIT = 4;
	localparam int ADMIN_MSB = 3;
	localparam int ADMIN_LSB = 0;
	localparam logic [3:0] ADMIN_NONE = 4'h0;
	localparam logic [3:0] ADMIN_TYPE_A_NOTICE = 4'h8;
	localparam logic [3:0] ADMIN_PASSIVE_INIT = 4'h9;
	localparam logic [3:0] ADMIN_REQ_INIT = 4'h1;
	localparam logic [3:0] ADMIN_REQ_HALT = 4'h2;
	localparam logic STRUCT_TYPE_A = 1'b0;
	localparam logic STRUCT_BYTES = 1'b1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] FULL_LAST_BITS = 4'h8;

	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_TYPE_A_NOTICE,
		CMD_PASSIVE_INIT
	} tx_admin_t;

	typedef enum logic [2:0] {
		RX_NONE,
		RX_REQ_INIT,
		RX_REQ_HALT,
		RX_RESERVED
	} rx_admin_t;
endpackage

// File: logic/tunnel_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface type_a_pad_if;
	logic [7:0] rawByte;
	logic [3:0] validBits;
	logic [7:0] paddedByte;
	modport pad (input rawByte, validBits, output paddedByte);
	modport user (output rawByte, validBits, input paddedByte);
endinterface
`default_nettype wire

// File: logic/type_a_pad.sv
`timescale 1ns/1ps
`default_nettype none
module type_a_pad
	import tunnel_codec_pkg::*;
(
	// last byte, count and masked byte
	type_a_pad_if.pad padPort
);
	// clear every bit at or above the valid count
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			padPort.paddedByte[i] = (4'(i) < padPort.validBits) ? padPort.rawByte[i] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: logic/tunnel_frame_command_codec.sv
`timescale 1ns/1ps
`default_nettype none
module tunnel_frame_command_codec
	import tunnel_codec_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// outbound frame request
	input wire logic txStart,
	input wire tx_admin_t txAdmin,
	input wire logic txByteAligned,
	input wire logic txDataValid,
	input wire logic [7:0] txData,
	input wire logic txDataLast,
	input wire logic [3:0] txLastBits,
	output logic txReady,
	// outbound link bytes
	output logic linkTxValid,
	output logic [7:0] linkTxByte,
	output logic linkTxLast,
	// inbound link bytes from card
	input wire logic linkRxValid,
	input wire logic [7:0] linkRxByte,
	input wire logic linkRxLast,
	// inbound decode
	output logic rxCmdValid,
	output rx_admin_t rxAdmin,
	output logic rxByteAligned,
	output logic rxMarkerError,
	output logic rxDataValid,
	output logic [7:0] rxData,
	output logic rxFrameDone,
	output logic rxNoReply,
	output logic [5:0] rxByteCount,
	output logic [8:0] rxBitCount
);
	typedef enum logic [1:0] {TX_IDLE, TX_CMD, TX_DATA} tx_state_t;

	tx_state_t txState;
	logic txAlignedHeld;
	logic [3:0] txAdminHeld;
	logic txSendCmd;
	logic txSendData;
	logic rxExpectCmd;
	logic rxCmdByte;
	logic rxDataByte;
	logic [5:0] rxNextCount;
	logic [7:0] paddedByte;
	type_a_pad_if padBus ();

	//------------------------------------------------------------
	// code tables and counts
	//------------------------------------------------------------
	function automatic logic [3:0] admin_code(input tx_admin_t a);
		unique case (a)
			CMD_TYPE_A_NOTICE: admin_code = ADMIN_TYPE_A_NOTICE;
			CMD_PASSIVE_INIT: admin_code = ADMIN_PASSIVE_INIT;
			default: admin_code = ADMIN_NONE;
		endcase
	endfunction

	// card table only: same code means other things from us
	function automatic rx_admin_t card_admin(input logic [3:0] c);
		unique case (c)
			ADMIN_NONE: card_admin = RX_NONE;
			ADMIN_REQ_INIT: card_admin = RX_REQ_INIT;
			ADMIN_REQ_HALT: card_admin = RX_REQ_HALT;
			default: card_admin = RX_RESERVED;
		endcase
	endfunction

	// type A: n bytes -> 9*(n-1) bits, one byte -> 4 bits from card
	function automatic logic [8:0] type_a_bits(input logic [5:0] n);
		if (n == 6'h00) begin
			type_a_bits = 9'h000;
		end else if (n == 6'h01) begin
			type_a_bits = 9'h004;
		end else begin
			type_a_bits = 9'(({3'h0, n} - 9'h001) * 9'h009);
		end
	endfunction

	//------------------------------------------------------------
	// transmit
	//------------------------------------------------------------
	assign padBus.rawByte = txData;
	assign padBus.validBits = txLastBits;
	assign paddedByte = padBus.paddedByte;

	type_a_pad uPad (
		.padPort(padBus.pad)
	);

	assign txReady = (txState == TX_IDLE) || (txState == TX_DATA);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			txState <= TX_IDLE;
			txAlignedHeld <= STRUCT_BYTES;
			txAdminHeld <= ADMIN_NONE;
		end else begin
			unique case (txState)
				TX_IDLE: if (txStart) begin
					txState <= TX_CMD;
					txAlignedHeld <= txByteAligned;
					txAdminHeld <= admin_code(txAdmin);
				end
				TX_CMD: txState <= TX_DATA;
				TX_DATA: if (txDataValid && txDataLast) begin
					txState <= TX_IDLE;
				end
			endcase
		end
	end

	assign txSendCmd = (txState == TX_CMD);
	assign txSendData = (txState == TX_DATA) && txDataValid;

	// command byte never ends a frame: a frame always has payload
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			linkTxValid <= 1'b0;
			linkTxLast <= 1'b0;
		end else begin
			linkTxValid <= txSendCmd || txSendData;
			linkTxLast <= txSendData && txDataLast;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			linkTxByte <= RESET_BYTE;
		end else if (txSendCmd) begin
			linkTxByte <= {FRAME_MARKER, txAlignedHeld, txAdminHeld};
		end else if (txSendData && txDataLast && txAlignedHeld == STRUCT_TYPE_A) begin
			linkTxByte <= paddedByte;
		end else if (txSendData) begin
			linkTxByte <= txData;
		end
	end

	//------------------------------------------------------------
	// receive command
	//------------------------------------------------------------
	assign rxCmdByte = linkRxValid && rxExpectCmd;
	assign rxDataByte = linkRxValid && !rxExpectCmd;
	assign rxNextCount = rxByteCount + 6'h01;

	// first byte after reset or after a last byte is the command
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxExpectCmd <= 1'b1;
		end else if (linkRxValid) begin
			rxExpectCmd <= linkRxLast;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxCmdValid <= 1'b0;
			rxAdmin <= RX_NONE;
			rxByteAligned <= STRUCT_BYTES;
			rxMarkerError <= 1'b0;
		end else begin
			rxCmdValid <= rxCmdByte;
			if (rxCmdByte) begin
				rxAdmin <= card_admin(linkRxByte[ADMIN_MSB:ADMIN_LSB]);
				rxByteAligned <= linkRxByte[STRUCT_BIT];
				rxMarkerError <= linkRxByte[MARKER_MSB:MARKER_LSB] != FRAME_MARKER;
			end
		end
	end

	//------------------------------------------------------------
	// receive payload and counts
	//------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxDataValid <= 1'b0;
			rxData <= RESET_BYTE;
		end else begin
			rxDataValid <= rxDataByte;
			if (rxDataByte) begin
				rxData <= linkRxByte;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxByteCount <= 6'h00;
			rxBitCount <= 9'h000;
		end else if (rxCmdByte) begin
			rxByteCount <= 6'h00;
			rxBitCount <= 9'h000;
		end else if (rxDataByte) begin
			rxByteCount <= rxNextCount;
			if (rxByteAligned) begin
				rxBitCount <= {rxNextCount, 3'h0};
			end else begin
				rxBitCount <= type_a_bits(rxNextCount);
			end
		end
	end

	//------------------------------------------------------------
	// receive frame end
	//------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxFrameDone <= 1'b0;
			rxNoReply <= 1'b0;
		end else begin
			rxFrameDone <= linkRxValid && linkRxLast;
			if (linkRxValid && linkRxLast) begin
				rxNoReply <= rxExpectCmd;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/card_endpoint_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_endpoint_model (
	// bench side and link side
	input wire logic clk_sys,
	input wire logic sendValid,
	input wire logic [7:0] sendByte,
	input wire logic sendLast,
	output logic linkRxValid,
	output logic [7:0] linkRxByte,
	output logic linkRxLast
);
	// released byte flips so stale data never looks held
	always @(posedge clk_sys) begin
		linkRxValid <= sendValid;
		linkRxLast <= sendLast;
		linkRxByte <= sendValid ? sendByte : ~sendByte;
	end
endmodule
`default_nettype wire

// File: tb/tunnel_codec_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tunnel_codec_sva
	import tunnel_codec_pkg::*;
(
	// watched ports
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic txStart,
	input wire logic txByteAligned,
	input wire logic txDataValid,
	input wire logic txDataLast,
	input wire logic [3:0] txLastBits,
	input wire logic linkTxValid,
	input wire logic [7:0] linkTxByte,
	input wire logic linkTxLast,
	input wire logic linkRxValid,
	input wire logic [7:0] linkRxByte,
	input wire logic linkRxLast,
	input wire logic rxCmdValid,
	input wire rx_admin_t rxAdmin,
	input wire logic rxByteAligned,
	input wire logic rxMarkerError,
	input wire logic rxDataValid,
	input wire logic [7:0] rxData
);
	logic idle, aligned, rxFirst;
	logic [1:0] pend;
	logic [7:0] lastRx;
	logic dataState;
	assign dataState = !idle && !pend[0];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idle <= 1'b1;
			pend <= 2'b00;
			aligned <= 1'b0;
		end else begin
			pend <= {pend[0], txStart && idle};
			if (txStart && idle) begin
				idle <= 1'b0;
				aligned <= txByteAligned;
			end else if (dataState && txDataValid && txDataLast) begin
				idle <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rxFirst <= 1'b1;
			lastRx <= 8'h00;
		end else if (linkRxValid) begin
			rxFirst <= linkRxLast;
			lastRx <= linkRxByte;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_cmd_marker: assert property (pend[1] |-> linkTxValid && linkTxByte[7:5] == 3'b010)
		else $error("command byte late or marker wrong");
	a_struct_bit: assert property (pend[1] |-> linkTxByte[4] == aligned)
		else $error("structure bit wrong");
	a_no_reserved: assert property (pend[1] |-> linkTxByte[3:0] inside {4'h0, 4'h8, 4'h9})
		else $error("reserved admin code sent");
	a_data_follow: assert property (dataState && txDataValid |=>
		linkTxValid && linkTxLast == $past(txDataLast))
		else $error("payload byte not forwarded");
	a_pad_zero: assert property (dataState && txDataValid && txDataLast && !aligned |=>
		(linkTxByte >> $past(txLastBits)) == 8'h00)
		else $error("padding bits not zero");
	a_rx_cmd: assert property (linkRxValid && rxFirst |=> rxCmdValid && rxByteAligned == lastRx[4]
		&& rxMarkerError == (lastRx[7:5] != 3'b010))
		else $error("command byte decode wrong");
	a_rx_admin: assert property (rxCmdValid |-> rxAdmin == (lastRx[3:0] == 4'h0 ? RX_NONE :
		lastRx[3:0] == 4'h1 ? RX_REQ_INIT : lastRx[3:0] == 4'h2 ? RX_REQ_HALT : RX_RESERVED))
		else $error("admin decode wrong");
	a_rx_data: assert property (linkRxValid && !rxFirst |=> rxDataValid && rxData == lastRx)
		else $error("payload byte lost");
endmodule
bind tunnel_frame_command_codec tunnel_codec_sva chk (.clk_sys, .rst_n, .txStart, .txByteAligned,
	.txDataValid, .txDataLast, .txLastBits, .linkTxValid, .linkTxByte, .linkTxLast, .linkRxValid,
	.linkRxByte, .linkRxLast, .rxCmdValid, .rxAdmin, .rxByteAligned, .rxMarkerError,
	.rxDataValid, .rxData);
`default_nettype wire

// File: tb/tunnel_frame_command_codec_test.sv
`timescale 1ns/1ps
`default_nettype none
module tunnel_frame_command_codec_test
	import tunnel_codec_pkg::*;
;
	logic clk_sys, rst_n, txStart, txByteAligned, txDataValid, txDataLast, txReady;
	logic linkTxValid, linkTxLast, linkRxValid, linkRxLast, rxCmdValid, rxByteAligned;
	logic rxMarkerError, rxDataValid, rxFrameDone, rxNoReply, sendValid, sendLast;
	logic [7:0] txData, linkTxByte, linkRxByte, rxData, sendByte;
	logic [3:0] txLastBits;
	logic [5:0] rxByteCount;
	logic [8:0] rxBitCount;
	tx_admin_t txAdmin;
	rx_admin_t rxAdmin;
	int miscompares = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [3:0] codes [3] = '{4'h0, 4'h8, 4'h9};
	tunnel_frame_command_codec uut (.clk_sys, .rst_n, .txStart, .txAdmin, .txByteAligned,
		.txDataValid, .txData, .txDataLast, .txLastBits, .txReady, .linkTxValid, .linkTxByte,
		.linkTxLast, .linkRxValid, .linkRxByte, .linkRxLast, .rxCmdValid, .rxAdmin,
		.rxByteAligned, .rxMarkerError, .rxDataValid, .rxData, .rxFrameDone, .rxNoReply,
		.rxByteCount, .rxBitCount);
	card_endpoint_model card (.clk_sys, .sendValid, .sendByte, .sendLast, .linkRxValid,
		.linkRxByte, .linkRxLast);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one frame per admin code, both structures
	task automatic tx_frame(input int i);
		int got;
		got = 0;
		@(posedge clk_sys);
		txAdmin <= tx_admin_t'(i);
		txByteAligned <= i[0];
		txLastBits <= 4'(3 * i + 1);
		txStart <= 1'b1;
		txDataValid <= 1'b1;
		@(posedge clk_sys);
		txStart <= 1'b0;
		#1;
		check(16'(txReady), 16'h0000);
		repeat (6) begin
			#1;
			if (linkTxValid && !linkTxLast && got == 0) begin
				check(16'(linkTxByte), {8'h00, 3'b010, i[0], codes[i]});
				got++;
			end else if (linkTxValid && linkTxLast) begin
				check(16'(linkTxByte), i[0] ? 16'h00ff : 16'(8'hff >> (7 - 3 * i)));
				got++;
			end
			@(posedge clk_sys);
		end
		txDataValid <= 1'b0;
		check(16'(got), 16'h0002);
	endtask
	task automatic rx_frame(input logic [7:0] cmd, input logic withData, input rx_admin_t exp);
		int got;
		got = 0;
		@(posedge clk_sys);
		sendValid <= 1'b1;
		sendByte <= cmd;
		sendLast <= !withData;
		if (withData) begin
			@(posedge clk_sys);
			sendByte <= 8'h3c;
			sendLast <= 1'b1;
		end
		@(posedge clk_sys);
		sendValid <= 1'b0;
		sendLast <= 1'b0;
		repeat (6) begin
			#1;
			if (rxFrameDone) begin
				got++;
				check(16'(rxAdmin), 16'(exp));
				check(16'(rxNoReply), 16'(!withData));
				check(16'(rxMarkerError), 16'(cmd[7:5] != 3'b010));
				check(16'(rxByteCount), 16'(withData));
				check(16'(rxBitCount), withData ? (cmd[4] ? 16'h0008 : 16'h0004) : 16'h0000);
			end
			@(posedge clk_sys);
		end
		check(16'(got), 16'h0001);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		{rst_n, txStart, txByteAligned, txDataValid, sendValid, sendLast} = 6'h00;
		txData = 8'hff;
		txDataLast = 1'b1;
		txLastBits = 4'h8;
		sendByte = 8'h00;
		txAdmin = CMD_NONE;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++) tx_frame(i);
		rx_frame(8'h41, 1'b1, RX_REQ_INIT);
		rx_frame(8'h52, 1'b1, RX_REQ_HALT);
		rx_frame(8'h50, 1'b0, RX_NONE);
		rx_frame(8'h45, 1'b1, RX_RESERVED);
		rx_frame(8'h85, 1'b1, RX_RESERVED);
		finish_test();
	end
endmodule
`default_nettype wire
